// ===== inc/stack_op_pkg.sv
package stack_op_pkg;
  // =====================================================
  // register offsets (byte addresses, one word each)
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_BANK   = 12'h004;
  localparam logic [11:0] OFF_PTR0   = 12'h008;
  localparam logic [11:0] OFF_PTR1   = 12'h00C;
  localparam logic [11:0] OFF_PTR2   = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_PC     = 12'h018;
  // field positions
  localparam int CTRL_EXT_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_BAD_BIT   = 1;
  // values after reset
  localparam logic        RST_EXT = 1'b0;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [11:0] RST_PTR  = 12'h000;
  localparam logic [20:0] RST_PC  = 21'h000000;
  // opcodes
  localparam logic [7:0]  OP_PUSH = 8'hFA;
  localparam logic [7:0]  OP_SUB  = 8'hE9;
  localparam logic [7:0]  OP_MOV  = 8'hEB;
  localparam logic [3:0]  W2_PFX  = 4'hF;
  localparam logic [1:0]  SEL_RET = 2'h3;
  // access bank split and upper bank
  localparam logic [7:0]  ACC_LIMIT = 8'h5F;
  localparam logic [3:0]  ACC_HI    = 4'hF;
  localparam logic [3:0]  ACC_LO    = 4'h0;
  // special data addresses (plain defaults)
  localparam logic [11:0] ADR_IND0 = 12'hFF0;
  localparam logic [11:0] ADR_IND1 = 12'hFF1;
  localparam logic [11:0] ADR_IND2 = 12'hFF2;
  localparam logic [11:0] ADR_PC_LOW = 12'hFF9;
  localparam logic [11:0] ADR_STK_UP = 12'hFFD;
  localparam logic [11:0] ADR_STK_HI = 12'hFFE;
  localparam logic [11:0] ADR_STK_LO = 12'hFFF;
  localparam logic [11:0] ONE12    = 12'h001;

  typedef enum logic [2:0] {
    S_IDLE   = 3'b001,
    S_MVDST  = 3'b010,
    S_RETNOP = 3'b100
  } state_t;

  typedef struct packed {
    state_t      state;
    logic        ext_en;
    logic [3:0]  bank_sel;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] frame_ptr;
    logic [20:0] pc;
    logic [7:0]  hold;
    logic        data_ok;
    logic        src_ind;
    logic        bad_op;
    logic [31:0] prdata;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_we;
    logic        mem_re;
    logic        ret;
    logic [11:0] xlat_addr;
    logic        xlat_w;
    logic        xlat_valid;
  } st_t;
endpackage

// ===== core/indexed_stack_op_decoder.sv
// Operation
// - two-word move; word1 EB plus 1 and source offset, word2 F and dest offset
// - move addresses span the whole 12-bit, 4096-byte data space
// - move never writes program counter low or any stack top byte
// - move source on an indirect register reads as 00h
// - move destination on an indirect register performs no write
// - move keeps flags, reads source first cycle, writes destination second
// - literal push writes literal at frame pointer, one cycle, no flags
// - after push the frame pointer decrements by one
// - pointer subtract takes 6-bit literal from selected pointer 0 to 2
// - select 11 subtracts from frame pointer, returns, then idles one cycle
// - extension enable also turns on indexed literal-offset addressing
// - extension off: access bank when a is 0, bank select when 1
// - extension on, a 0, operand up to 5Fh adds to frame pointer
// - translation serves every byte and bit instruction with access bit
// - frame pointer 00h maps offsets onto the original access bank
// - destination bit keeps its meaning: working register or location
// - extension enable bit resets to 0, extension disabled
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ns
module indexed_stack_op_decoder (
  input  wire logic        pclk,        // core clock
  input  wire logic        presetn,     // async reset, low
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb access phase
  input  wire logic        pwrite,      // apb write
  input  wire logic [11:0] paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb unmapped access
  input  wire logic        instr_valid, // instruction word offered
  input  wire logic [15:0] instr_word,  // instruction word
  output logic             instr_ready, // word taken this cycle
  input  wire logic [20:0] return_stack_top,         // return stack top
  output logic      [20:0] pc,          // program counter
  output logic             ret_pulse,   // return taken
  output logic      [11:0] mem_addr,    // data memory address
  output logic      [7:0]  mem_wdata,   // data memory write data
  output logic             mem_we,      // write strobe
  output logic             mem_re,      // read strobe
  input  wire logic [7:0]  mem_rdata,   // read data, same cycle as re
  input  wire logic        std_valid,   // standard operand offered
  input  wire logic [7:0]  std_f,       // file register field
  input  wire logic        std_a,       // access select bit
  input  wire logic        std_d,       // destination bit
  output logic      [11:0] xlat_addr,   // translated address
  output logic             xlat_to_w,   // result to working reg
  output logic             xlat_valid   // translation valid
);

  // =====================================================
  // helpers
  function automatic logic is_ind(input logic [11:0] a);
    case (a)
      stack_op_pkg::ADR_IND0,
      stack_op_pkg::ADR_IND1,
      stack_op_pkg::ADR_IND2: is_ind = 1'b1;
      default:                is_ind = 1'b0;
    endcase
  endfunction

  function automatic logic is_prot(input logic [11:0] a);
    case (a)
      stack_op_pkg::ADR_PC_LOW,
      stack_op_pkg::ADR_STK_UP,
      stack_op_pkg::ADR_STK_HI,
      stack_op_pkg::ADR_STK_LO: is_prot = 1'b1;
      default:                  is_prot = 1'b0;
    endcase
  endfunction

  // sum is taken at 12 bits so it wraps rather than carries out
  function automatic logic [11:0] fp_add(
    input logic [11:0] fp,
    input logic [6:0]  z
  );
    fp_add = fp + {5'h00, z};
  endfunction

  // =====================================================
  // state
  stack_op_pkg::st_t r, n;

  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic        take;
  logic [7:0]  op_hi;
  logic [7:0]  op_lo;
  logic [11:0] src_a;
  logic [11:0] dst_a;
  logic [7:0]  mv_data;
  logic [5:0]  k6;
  logic [11:0] sub_k;

  assign op_hi = instr_word[15:8];
  assign op_lo = instr_word[7:0];
  assign k6    = instr_word[5:0];
  assign sub_k = {6'h00, k6};
  assign src_a = fp_add(r.frame_ptr, instr_word[6:0]);
  assign dst_a = fp_add(r.frame_ptr, instr_word[6:0]);

  // =====================================================
  // opcode classes; extended words only count with the extension on
  logic        op_push;
  logic        op_sub;
  logic        op_mov1;
  logic        op_mov2;

  assign op_push = (op_hi == stack_op_pkg::OP_PUSH);
  assign op_sub  = (op_hi == stack_op_pkg::OP_SUB);
  assign op_mov1 = (op_hi == stack_op_pkg::OP_MOV) & instr_word[7];
  assign op_mov2 = (instr_word[15:12] == stack_op_pkg::W2_PFX);

  // =====================================================
  // pointer arithmetic, all taken at 12 bits so it wraps
  logic [11:0] ptr0_sub;
  logic [11:0] ptr1_sub;
  logic [11:0] frame_sub;
  logic [11:0] frame_dec;

  assign ptr0_sub  = r.ptr0 - sub_k;
  assign ptr1_sub  = r.ptr1 - sub_k;
  assign frame_sub = r.frame_ptr - sub_k;
  assign frame_dec = r.frame_ptr - stack_op_pkg::ONE12;

  // =====================================================
  // apb decode; reads answer in the first access cycle
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb begin
    unique case (paddr)
      stack_op_pkg::OFF_CTRL,
      stack_op_pkg::OFF_BANK,
      stack_op_pkg::OFF_PTR0,
      stack_op_pkg::OFF_PTR1,
      stack_op_pkg::OFF_PTR2,
      stack_op_pkg::OFF_STATUS,
      stack_op_pkg::OFF_PC: hit = 1'b1;
      default:              hit = 1'b0;
    endcase
  end

  // no wait states: every access ends in its first access cycle
  assign pready    = 1'b1;
  // unmapped offsets answer with an error and read as zero
  assign pslverr   = psel & penable & ~hit;
  assign instr_ready = (r.state != stack_op_pkg::S_RETNOP);
  assign take      = instr_valid & instr_ready;

  // source byte: held copy, or memory answer in the first dest cycle;
  // an indirect source never strobes memory, so its byte is forced
  always_comb begin
    if (r.src_ind) begin
      mv_data = 8'h00;
    end else if (r.data_ok) begin
      mv_data = r.hold;
    end else begin
      mv_data = mem_rdata;
    end
  end

  // =====================================================
  // operand translation for standard byte and bit instructions
  logic [11:0] xl_addr;

  always_comb begin
    if (std_a) begin
      xl_addr = {r.bank_sel, std_f};
    end else if (r.ext_en && std_f <= stack_op_pkg::ACC_LIMIT) begin
      // a zero pointer lands on the old access bank
      xl_addr = fp_add(r.frame_ptr, std_f[6:0]);
    end else if (std_f <= stack_op_pkg::ACC_LIMIT) begin
      xl_addr = {stack_op_pkg::ACC_LO, std_f};
    end else begin
      xl_addr = {stack_op_pkg::ACC_HI, std_f};
    end
  end

  // =====================================================
  // next state
  always_comb begin
    n            = r;
    n.mem_we     = 1'b0;
    n.mem_re     = 1'b0;
    n.ret        = 1'b0;
    n.xlat_valid = 1'b0;
    // strobes default low so each stands for one cycle only

    // software writes first so instruction updates win below
    if (wr_acc) begin
      unique case (paddr)
        stack_op_pkg::OFF_CTRL:
          n.ext_en = pwdata[stack_op_pkg::CTRL_EXT_BIT];
        stack_op_pkg::OFF_BANK: n.bank_sel  = pwdata[3:0];
        stack_op_pkg::OFF_PTR0: n.ptr0      = pwdata[11:0];
        stack_op_pkg::OFF_PTR1: n.ptr1      = pwdata[11:0];
        stack_op_pkg::OFF_PTR2: n.frame_ptr = pwdata[11:0];
        // an event in the same cycle sets the flag again below
        stack_op_pkg::OFF_STATUS:
          if (pwdata[stack_op_pkg::STAT_BAD_BIT]) begin
            n.bad_op = 1'b0;
          end
        default: ;
      endcase
    end

    if (rd_setup) begin
      n.prdata = 32'h00000000;
      unique case (paddr)
        stack_op_pkg::OFF_CTRL:
          n.prdata[stack_op_pkg::CTRL_EXT_BIT] = r.ext_en;
        stack_op_pkg::OFF_BANK: n.prdata[3:0]  = r.bank_sel;
        stack_op_pkg::OFF_PTR0: n.prdata[11:0] = r.ptr0;
        stack_op_pkg::OFF_PTR1: n.prdata[11:0] = r.ptr1;
        stack_op_pkg::OFF_PTR2: n.prdata[11:0] = r.frame_ptr;
        stack_op_pkg::OFF_STATUS: begin
          n.prdata[stack_op_pkg::STAT_BUSY_BIT] =
            (r.state != stack_op_pkg::S_IDLE);
          n.prdata[stack_op_pkg::STAT_BAD_BIT] = r.bad_op;
        end
        stack_op_pkg::OFF_PC: n.prdata[20:0] = r.pc;
        default: ;
      endcase
    end

    // operand translation for standard byte and bit instructions
    if (std_valid) begin
      n.xlat_valid = 1'b1;
      n.xlat_w     = ~std_d;
      n.xlat_addr  = xl_addr;
    end

    unique case (r.state)
      stack_op_pkg::S_IDLE: begin
        // extended opcodes decode only with the extension on
        if (take && r.ext_en) begin
          if (op_push) begin
            n.mem_addr  = r.frame_ptr;
            n.mem_wdata = op_lo;
            n.mem_we    = 1'b1;
            // underflow wraps silently; software keeps its own limits
            n.frame_ptr = frame_dec;
          end else if (op_sub) begin
            unique case (instr_word[7:6])
              2'h0: n.ptr0 = ptr0_sub;
              2'h1: n.ptr1 = ptr1_sub;
              2'h2: n.frame_ptr = frame_sub;
              stack_op_pkg::SEL_RET: begin
                n.frame_ptr = frame_sub;
                n.pc    = return_stack_top;
                n.ret   = 1'b1;
                n.state = stack_op_pkg::S_RETNOP;
              end
            endcase
          end else if (op_mov1) begin
            // first cycle issues the source read
            n.mem_addr = src_a;
            n.mem_re   = ~is_ind(src_a);
            n.src_ind  = is_ind(src_a);
            n.data_ok  = 1'b0;
            n.state    = stack_op_pkg::S_MVDST;
          end else begin
            n.bad_op = 1'b1;
          end
        end else if (take) begin
          n.bad_op = 1'b1;
        end
      end

      stack_op_pkg::S_MVDST: begin
        // keep the source byte in case word two is late
        if (!r.data_ok) begin
          n.hold    = mv_data;
          n.data_ok = 1'b1;
        end
        if (take) begin
          n.state = stack_op_pkg::S_IDLE;
          if (!op_mov2) begin
            n.bad_op = 1'b1;
          end else if (!is_ind(dst_a) && !is_prot(dst_a)) begin
            n.mem_addr  = dst_a;
            n.mem_wdata = mv_data;
            n.mem_we    = 1'b1;
          end
          // otherwise the move completes as a no-operation
        end
      end

      stack_op_pkg::S_RETNOP: begin
        // the return target is being fetched; no word is taken
        n.state = stack_op_pkg::S_IDLE;
      end
      default: n.state = stack_op_pkg::S_IDLE;
    endcase
  end

  // =====================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state      <= stack_op_pkg::S_IDLE;
      r.ext_en     <= stack_op_pkg::RST_EXT;
      r.bank_sel   <= stack_op_pkg::RST_BANK;
      r.ptr0       <= stack_op_pkg::RST_PTR;
      r.ptr1       <= stack_op_pkg::RST_PTR;
      r.frame_ptr  <= stack_op_pkg::RST_PTR;
      r.pc         <= stack_op_pkg::RST_PC;

      // move bookkeeping and status
      r.hold       <= 8'h00;
      r.data_ok    <= 1'b0;
      r.src_ind    <= 1'b0;
      r.bad_op     <= 1'b0;

      // registered outputs
      r.prdata     <= 32'h00000000;
      r.mem_addr   <= 12'h000;
      r.mem_wdata  <= 8'h00;
      r.mem_we     <= 1'b0;
      r.mem_re     <= 1'b0;
      r.ret        <= 1'b0;
      r.xlat_addr  <= 12'h000;
      r.xlat_w     <= 1'b0;
      r.xlat_valid <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // =====================================================
  // outputs, all straight from flip-flops
  assign prdata     = r.prdata;
  assign pc         = r.pc;
  assign ret_pulse  = r.ret;
  assign mem_addr   = r.mem_addr;
  assign mem_wdata  = r.mem_wdata;
  assign mem_we     = r.mem_we;
  assign mem_re     = r.mem_re;
  assign xlat_addr  = r.xlat_addr;
  assign xlat_to_w  = r.xlat_w;
  assign xlat_valid = r.xlat_valid;

endmodule // indexed_stack_op_decoder

// ===== sim/stack_op_asserts.sv
`timescale 1ns/1ns
module stack_op_asserts (
  input wire logic        pclk,        // clock
  input wire logic        presetn,     // reset, low
  input wire logic        penable,     // apb access
  input wire logic        pwrite,      // apb write
  input wire logic [11:0] paddr,       // apb address
  input wire logic [31:0] pwdata,      // apb data
  input wire logic        instr_valid, // word offered
  input wire logic [15:0] instr_word,  // word
  input wire logic        instr_ready, // word taken
  input wire logic [20:0] return_stack_top,         // stack top
  input wire logic [20:0] pc,          // program counter
  input wire logic        ret_pulse,   // return taken
  input wire logic [11:0] mem_addr,    // mem address
  input wire logic [7:0]  mem_wdata,   // mem data
  input wire logic        mem_we,      // mem write
  input wire logic        mem_re,      // mem read
  input wire logic        std_valid,   // operand offered
  input wire logic [7:0]  std_f,       // file field
  input wire logic        std_a,       // access bit
  input wire logic        std_d,       // dest bit
  input wire logic [11:0] xlat_addr,   // translated
  input wire logic        xlat_to_w,   // to working reg
  input wire logic        xlat_valid   // valid
);
  // =====================================================
  // shadow of the extension bit; apb access implies select
  logic ext_r;
  logic mv_r;
  wire  take = instr_valid && instr_ready;
  wire  mv1 = ext_r && !mv_r && instr_word[15:7] == 9'h1D7;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_r <= 1'b0;
      mv_r  <= 1'b0;
    end else begin
      if (penable && pwrite && paddr == stack_op_pkg::OFF_CTRL)
        ext_r <= pwdata[0];
      if (take)
        mv_r <= mv1;
    end
  end
  // =====================================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ret_gap;
    !instr_ready ##1 instr_ready;
  endsequence
  a_push_store: assert property (
    take && ext_r && !mv_r && instr_word[15:8] == stack_op_pkg::OP_PUSH
    |=> mem_we && mem_wdata == $past(instr_word[7:0]))
    else $error("push byte not written");
  a_ret_seq: assert property (
    take && ext_r && !mv_r
    && instr_word[15:6] == {stack_op_pkg::OP_SUB, stack_op_pkg::SEL_RET}
    |=> (ret_pulse && pc == return_stack_top) ##0 s_ret_gap)
    else $error("return sequence wrong");
  a_ret_only: assert property (
    ret_pulse |-> $past(instr_word[7:6]) == stack_op_pkg::SEL_RET)
    else $error("return without select 11");
  a_xlat_time: assert property (
    std_valid |=> xlat_valid && xlat_to_w == !$past(std_d))
    else $error("translation late or wrong dest");
  a_xlat_high: assert property (
    std_valid && !std_a && std_f > stack_op_pkg::ACC_LIMIT
    |=> xlat_addr == {stack_op_pkg::ACC_HI, $past(std_f)})
    else $error("upper access bank moved");
  a_xlat_plain: assert property (
    std_valid && !std_a && !ext_r && std_f <= stack_op_pkg::ACC_LIMIT
    |=> xlat_addr == {stack_op_pkg::ACC_LO, $past(std_f)})
    else $error("plain access address wrong");
  a_move_guard: assert property (
    take && mv_r |=> !(mem_we && mem_addr inside {12'hFF0, 12'hFF1,
      12'hFF2, 12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF}))
    else $error("move wrote a protected place");
  a_move_first: assert property (
    take && mv1 |=> !mem_we)
    else $error("move wrote in first cycle");
  a_move_read: assert property (
    take && mv1 |=> mem_re == !(mem_addr inside {12'hFF0, 12'hFF1,
      12'hFF2}))
    else $error("move source read strobe wrong");
endmodule // stack_op_asserts
bind indexed_stack_op_decoder stack_op_asserts u_stack_op_asserts (
  .pclk, .presetn, .penable, .pwrite, .paddr, .pwdata, .instr_valid,
  .instr_word, .instr_ready, .return_stack_top, .pc, .ret_pulse, .mem_addr, .mem_wdata,
  .mem_we, .mem_re, .std_valid, .std_f, .std_a, .std_d, .xlat_addr, .xlat_to_w,
  .xlat_valid
);

// ===== sim/far_side_model.sv
`timescale 1ns/1ns
module far_side_model #(
  parameter logic [20:0] RET_ADDR = 21'h01A2B3 // plain default
) (
  input  wire logic        pclk,      // clock
  input  wire logic [11:0] mem_addr,  // address
  input  wire logic [7:0]  mem_wdata, // write data
  input  wire logic        mem_we,    // write strobe
  output logic      [7:0]  mem_rdata, // read data
  output logic      [20:0] return_stack_top        // stack top
);
  logic [7:0] mem [4096];
  // combinational read: a move samples its byte in the strobe cycle
  assign mem_rdata = mem[mem_addr];
  assign return_stack_top = RET_ADDR;
  always @(posedge pclk) begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
  end
endmodule // far_side_model

// ===== sim/indexed_stack_op_decoder_test.sv
`timescale 1ns/1ns
module indexed_stack_op_decoder_test;
  typedef struct packed {
    logic [11:0] fp;
    logic        ext, a;
    logic [7:0]  f;
    logic        d;
    logic [11:0] x;
  } row_t;
  localparam logic [20:0] RET = 21'h01A2B3;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr, mem_addr, xlat_addr;
  logic [31:0] pwdata, prdata, q;
  logic        instr_valid, instr_ready, ret_pulse, mem_we, mem_re;
  logic [15:0] instr_word;
  logic [20:0] return_stack_top, pc;
  logic [7:0]  mem_wdata, mem_rdata, std_f;
  logic        std_valid, std_a, std_d, xlat_to_w, xlat_valid;
  int          n_errors, num_checks;
  logic [6:0]  zd [3] = '{7'h72, 7'h79, 7'h7D};
  row_t        rows [9] = '{
    '{12'hA00, 1'b0, 1'b0, 8'h2C, 1'b0, 12'h02C},
    '{12'hA00, 1'b0, 1'b0, 8'h60, 1'b1, 12'hF60},
    '{12'hA00, 1'b0, 1'b1, 8'h2C, 1'b1, 12'h32C},
    '{12'hA00, 1'b1, 1'b0, 8'h2C, 1'b0, 12'hA2C},
    '{12'hA00, 1'b1, 1'b0, 8'h5F, 1'b1, 12'hA5F},
    '{12'hA00, 1'b1, 1'b0, 8'h60, 1'b0, 12'hF60},
    '{12'hA00, 1'b1, 1'b1, 8'h10, 1'b1, 12'h310},
    '{12'h000, 1'b1, 1'b0, 8'h2C, 1'b0, 12'h02C},
    '{12'hFF0, 1'b1, 1'b0, 8'h20, 1'b1, 12'h010}};
  indexed_stack_op_decoder u_indexed_stack_op_decoder (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .instr_valid, .instr_word, .instr_ready, .return_stack_top, .pc,
    .ret_pulse, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata,
    .std_valid, .std_f, .std_a, .std_d, .xlat_addr, .xlat_to_w, .xlat_valid);
  far_side_model #(.RET_ADDR(RET)) u_far_side_model (
    .pclk, .mem_addr, .mem_wdata, .mem_we, .mem_rdata, .return_stack_top);
  // =====================================================
  // tasks
  task automatic chk(input string n, input logic [31:0] x, g);
    num_checks++;
    if (g !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [11:0] a,
                    input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  task automatic mchk(input logic [11:0] a, input logic [7:0] x);
    chk("mem", {24'h0, x}, {24'h0, u_far_side_model.mem[a]});
  endtask
  // waits for the take, then lets any write land in memory
  task automatic ins(input logic [15:0] w);
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    @(negedge pclk);
    while (instr_ready !== 1'b1) @(negedge pclk);
    @(posedge pclk);
    instr_valid <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // =====================================================
  // clock, watchdog, sequence
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #(50 * 20000);
    n_errors++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {instr_valid, instr_word, std_valid, std_f, std_a, std_d} = '0;
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd("ext_en", stack_op_pkg::OFF_CTRL, 32'h0);
    rd("pc", stack_op_pkg::OFF_PC, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    u_far_side_model.mem[12'h000] = 8'h5A;
    ins(16'hFA77);
    mchk(12'h000, 8'h5A);
    rd("status", stack_op_pkg::OFF_STATUS, 32'h2);
    apb(1'b1, stack_op_pkg::OFF_BANK, 32'h3);
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, stack_op_pkg::OFF_CTRL, {31'h0, rows[i].ext});
      apb(1'b1, stack_op_pkg::OFF_PTR2, {20'h0, rows[i].fp});
      @(posedge pclk);
      std_valid <= 1'b1;
      {std_f, std_a, std_d} <= {rows[i].f, rows[i].a, rows[i].d};
      @(posedge pclk);
      std_valid <= 1'b0;
      #1;
      chk("xlat_addr", {20'h0, rows[i].x}, {20'h0, xlat_addr});
      chk("xlat_to_w", {31'h0, !rows[i].d}, {31'h0, xlat_to_w});
    end
    apb(1'b1, stack_op_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, stack_op_pkg::OFF_PTR2, 32'h001);
    ins(16'hFA08);
    ins(16'hFA09);
    mchk(12'h001, 8'h08);
    mchk(12'h000, 8'h09);
    rd("ptr2", stack_op_pkg::OFF_PTR2, 32'hFFF);
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, stack_op_pkg::OFF_PTR0 + 12'(4 * f), 32'h3FF);
      ins({stack_op_pkg::OP_SUB, 2'(f), 6'h23});
      rd("ptr", stack_op_pkg::OFF_PTR0 + 12'(4 * f), 32'h3DC);
    end
    apb(1'b1, stack_op_pkg::OFF_PTR2, 32'h3FF);
    ins({stack_op_pkg::OP_SUB, stack_op_pkg::SEL_RET, 6'h23});
    rd("ptr2", stack_op_pkg::OFF_PTR2, 32'h3DC);
    rd("pc", stack_op_pkg::OFF_PC, {11'h0, RET});
    apb(1'b1, stack_op_pkg::OFF_PTR2, 32'h080);
    u_far_side_model.mem[12'h085] = 8'h33;
    ins(16'hEB85);
    ins(16'hF006);
    mchk(12'h086, 8'h33);
    apb(1'b1, stack_op_pkg::OFF_PTR2, 32'hF80);
    u_far_side_model.mem[12'hF81] = 8'hAA;
    ins(16'hEBF0);
    ins(16'hF001);
    mchk(12'hF81, 8'h00);
    for (int i = 0; i < 3; i++) begin
      u_far_side_model.mem[12'hF80 + 12'(zd[i])] = 8'hC3;
      ins(16'hEB85);
      ins({9'h1E0, zd[i]});
      mchk(12'hF80 + 12'(zd[i]), 8'hC3);
    end
    apb(1'b1, stack_op_pkg::OFF_STATUS, 32'h2);
    rd("status", stack_op_pkg::OFF_STATUS, 32'h0);
    ins(16'hEB85);
    ins(16'h0006);
    rd("status", stack_op_pkg::OFF_STATUS, 32'h2);
    print_verdict();
  end
endmodule // indexed_stack_op_decoder_test
